// ==== pkg/tef_regs.vh ====
// Purpose: Register map and field positions of the timer event slice
// Assumes: 32-bit AXI4-Lite, one aligned word per register
// Notes:   Offsets are local choices
`ifndef TEF_REGS_VH
`define TEF_REGS_VH
`define TEF_OFS_ENABLE   4'h0
`define TEF_OFS_STATUS   4'h4
`define TEF_OFS_SWEVT    4'h8
`define TEF_OFS_CHMODE   4'hc
`define TEF_OFS_CTRL     4'h0
`define TEF_ENABLE_MASK  16'h7fff
`define TEF_STATUS_MASK  16'h1eff
`define TEF_SWEVT_MASK   16'h00ff
`define TEF_CTRL_MASK    16'h003f
`define TEF_RESET_VALUE  16'h0000
`define TEF_BIT_BRK      7
`define TEF_BIT_TRG      6
`define TEF_BIT_HALL     5
`define TEF_BIT_OVF      0
`define TEF_BIT_DMA_OVF  8
`define TEF_BIT_DMA_HALL 13
`define TEF_BIT_DMA_TRG  14
`define TEF_BIT_RECAP    9
`define TEF_BIT_CH1_DIR  0
`define TEF_BIT_CH2_DIR  8
`define TEF_BIT_CH1_SW   7
`define TEF_BIT_CH2_SW   15
`define TEF_MODE_SUSPEND 3'h5
`define TEF_DIR_OUTPUT   2'h0
`define TEF_DIR_OWN      2'h1
`define TEF_DIR_CROSS    2'h2
`define TEF_DIR_TRIGGER  2'h3
`define TEF_OC_OFF       3'h0
`define TEF_OC_SET       3'h1
`define TEF_OC_CLEAR     3'h2
`define TEF_OC_TOGGLE    3'h3
`define TEF_OC_LOW       3'h4
`define TEF_OC_HIGH      3'h5
`define TEF_OC_PWM_A     3'h6
`define TEF_OC_PWM_B     3'h7
`endif

// ==== core/tef_event_flags.v ====
// Purpose: Event flags, interrupt and DMA enables, software events and
//          channel 1/2 mode register of an advanced timer, on AXI4-Lite
// Assumes: Counter, capture inputs and break come from the rest of the timer
// Notes:   Notes on behaviour below
//
// Notes on behaviour
// - DMA enables for ch4..ch1, overflow at 12..8
// - Interrupt enables bits 7..0, reset disabled
// - Recapture flag when capture hits set flag
// - Write zero clears flag, one keeps it
// - Break flag set while break input active
// - Trigger flag on edge, any edge suspend
// - Commutation flag on preload update event
// - Input mode: capture sets, read/zero clears
// - Output mode: compare sets, zero write clears
// - Overflow flag; extra sources when both bits zero
// - Software event register fires matching events
// - Software commutation only for complementary channels
// - Clear input forces ch1 raw reference low
// - Ch2 direction field decodes output or sources
// - Mode bits meaning follows channel direction
// - Ch2 fields bits 15..10, ch1 bits 7..2
// - Trigger and commutation DMA enables bits 14, 13
// - Output control decode of raw reference
`timescale 1ns/10ps
`include "tef_regs.vh"
module tef_event_flags #(
  parameter CW = 16
) (
  input  wire          aclk,
  input  wire          aresetn,
  input  wire [3:0]    s_axi_awaddr,
  input  wire          s_axi_awvalid,
  output wire          s_axi_awready,
  input  wire [31:0]   s_axi_wdata,
  input  wire [3:0]    s_axi_wstrb,
  input  wire          s_axi_wvalid,
  output wire          s_axi_wready,
  output reg  [1:0]    s_axi_bresp,
  output reg           s_axi_bvalid,
  input  wire          s_axi_bready,
  input  wire [3:0]    s_axi_araddr,
  input  wire          s_axi_arvalid,
  output wire          s_axi_arready,
  output reg  [31:0]   s_axi_rdata,
  output reg  [1:0]    s_axi_rresp,
  output reg           s_axi_rvalid,
  input  wire          s_axi_rready,
  input  wire          break_active,
  input  wire          slave_trigger_line,
  input  wire          clear_input_pin,
  input  wire [2:0]    slave_mode,
  input  wire          trigger_source_internal,
  input  wire          overflow_event_disable,
  input  wire          overflow_source_select,
  input  wire          counter_overflow,
  input  wire          trigger_reinit,
  input  wire          preload_update,
  input  wire [3:0]    channel_enable_bit,
  input  wire [3:0]    has_complementary,
  input  wire [3:0]    ch_is_input,
  input  wire [3:0]    capture_event,
  input  wire [3:0]    compare_event,
  input  wire [3:0]    data_reg_read,
  input  wire          ch1_filtered_own,
  input  wire          ch1_filtered_to_ch2,
  input  wire          ch2_filtered_own,
  input  wire          internal_trigger_capture_src,
  input  wire [CW-1:0] counter_value,
  input  wire [CW-1:0] ch1_compare_value,
  input  wire          count_down,
  output wire          timer_irq,
  output wire [6:0]    dma_req,
  output wire          sw_trigger_pulse,
  output wire          sw_break_pulse,
  output wire [3:0]    commutation_apply,
  output wire          ch2_capture_input,
  output wire          ch2_capture_valid,
  output reg           ch1_raw_output_ref,
  output wire          ch1_output_connected,
  output wire [15:0]   channel_pair_a_mode_q
);

  reg  [15:0] dma_and_irq_enable;
  reg  [15:0] event_status_flags;
  reg  [15:0] channel_pair_a_mode;
  reg  [7:0]  sw_fire;
  reg         have_aw;
  reg         have_w;
  reg  [3:0]  aw_addr;
  reg  [31:0] w_data;
  reg  [3:0]  w_strb;

  // One write at a time: new address or data waits for the response
  wire wr_go = have_aw && have_w && !s_axi_bvalid;
  wire [15:0] wr16 = {w_strb[1] ? w_data[15:8] : 8'h00, w_strb[0] ? w_data[7:0] : 8'h00};
  wire [15:0] keep = {{8{w_strb[1]}}, {8{w_strb[0]}}};

  assign s_axi_awready = !have_aw && !s_axi_bvalid;
  assign s_axi_wready  = !have_w && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  function hit;
    input [3:0] a;
    input [3:0] ofs;
    begin
      hit = (a[3:2] == ofs[3:2]);
    end
  endfunction

  // Byte-lane merge of a register write; lanes 2 and 3 have no storage
  function [15:0] merge;
    input [15:0] old;
    input [15:0] wd;
    input [15:0] lanes;
    begin
      merge = (old & ~lanes) | (wd & lanes);
    end
  endfunction

  // Pin inputs: bit 0 trigger, bit 1 clear, bit 2 break
  // Three stages; a level is taken only once stages two and three agree,
  // so a glitch shorter than one clock never reaches a flag
  wire [2:0] pin_raw = {break_active, clear_input_pin, slave_trigger_line};
  wire [2:0] pin_now;
  wire [2:0] pin_agree;
  wire [2:0] pin_held;
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_pin_sync
      reg [2:0] stage;
      reg       held;
      always @(posedge aclk) begin
        if (!aresetn) begin
          stage <= 3'h0;
          held  <= 1'b0;
        end else begin
          stage <= {stage[1:0], pin_raw[g]};
          if (stage[2] == stage[1])
            held <= stage[2];
        end
      end
      assign pin_now[g]   = stage[2];
      assign pin_agree[g] = (stage[2] == stage[1]);
      assign pin_held[g]  = held;
    end
  endgenerate

  // Held levels reset low like the idle pins, so reset makes no false edge
  wire trg_rise  = pin_agree[0] && pin_now[0] && !pin_held[0];
  wire trg_any   = pin_agree[0] && (pin_now[0] != pin_held[0]);
  wire clr_level = pin_held[1];
  wire brk_level = pin_held[2];

  // Event sources, software pulses included
  wire trg_event  = ((slave_mode == `TEF_MODE_SUSPEND) ? trg_any : trg_rise)
                    || sw_fire[`TEF_BIT_TRG];
  wire brk_event  = brk_level || sw_fire[`TEF_BIT_BRK];
  wire hall_event = preload_update || sw_fire[`TEF_BIT_HALL];
  wire ovf_alt    = !overflow_event_disable && !overflow_source_select;
  // Software and reinit overflows count only when both select bits are clear
  wire ovf_event  = counter_overflow
                    || (ovf_alt && (trigger_reinit || sw_fire[`TEF_BIT_OVF]));
  wire [3:0] ch_set = (ch_is_input & capture_event) | (~ch_is_input & compare_event)
                      | sw_fire[4:1];
  wire [3:0] recap = ch_is_input & capture_event & event_status_flags[4:1];

  assign sw_trigger_pulse  = sw_fire[`TEF_BIT_TRG];
  assign sw_break_pulse    = sw_fire[`TEF_BIT_BRK];
  // Hardware commutation reaches the outputs elsewhere; only the software one is routed here
  assign commutation_apply = {4{sw_fire[`TEF_BIT_HALL]}} & has_complementary;

  // Only enabled byte lanes clear; a one in the data leaves the flag alone
  wire st_wr = wr_go && hit(aw_addr, `TEF_OFS_STATUS);
  wire [15:0] st_clr = st_wr ? (keep & ~wr16) : 16'h0000;

  // Clears first, then every set of this cycle on top
  reg [15:0] next_status;
  reg [15:0] set_vec;
  integer i;
  always @* begin
    set_vec = 16'h0000;
    set_vec[`TEF_BIT_BRK]  = brk_event;
    set_vec[`TEF_BIT_TRG]  = trg_event;
    set_vec[`TEF_BIT_HALL] = hall_event;
    set_vec[`TEF_BIT_OVF]  = ovf_event;
    set_vec[4:1]           = ch_set;
    set_vec[12:9]          = recap;
    next_status = event_status_flags & ~st_clr;
    for (i = 1; i <= 4; i = i + 1) begin
      if (ch_is_input[i-1] && data_reg_read[i-1])
        next_status[i] = 1'b0;
    end
    next_status = (next_status | set_vec) & `TEF_STATUS_MASK; // Set wins over clear
  end

  // Register writes and the one-shot software events
  always @(posedge aclk) begin
    if (!aresetn) begin
      dma_and_irq_enable  <= `TEF_RESET_VALUE;
      event_status_flags  <= `TEF_RESET_VALUE;
      channel_pair_a_mode <= `TEF_RESET_VALUE;
      sw_fire             <= 8'h00;
    end else begin
      event_status_flags <= next_status;
      // Fire bits last one clock; nothing stays armed between writes
      sw_fire <= 8'h00;
      if (wr_go && hit(aw_addr, `TEF_OFS_ENABLE))
        dma_and_irq_enable <= merge(dma_and_irq_enable, wr16, keep)
                              & `TEF_ENABLE_MASK;
      if (wr_go && hit(aw_addr, `TEF_OFS_SWEVT))
        sw_fire <= wr16[7:0];
      if (wr_go && hit(aw_addr, `TEF_OFS_CHMODE)) begin
        // Direction fields are taken as written; enable checks are software's job
        channel_pair_a_mode <= merge(channel_pair_a_mode, wr16, keep);
      end
    end
  end

  // AXI write channel
  // Address and data halves are held until both are in; the write then frees them and raises the response
  always @(posedge aclk) begin
    if (!aresetn) begin
      have_aw      <= 1'b0;
      have_w       <= 1'b0;
      aw_addr      <= 4'h0;
      w_data       <= 32'h0000_0000;
      w_strb       <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        have_aw <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        have_w <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_go) begin
        have_aw      <= 1'b0;
        have_w       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= 2'h0;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // AXI read channel; unmapped offsets cannot occur in a 16-byte window
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= 2'h0;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= 2'h0;
        case (s_axi_araddr[3:2])
          2'h0:    s_axi_rdata <= {16'h0000, dma_and_irq_enable};
          2'h1:    s_axi_rdata <= {16'h0000, event_status_flags};
          2'h2:    s_axi_rdata <= 32'h0000_0000; // Fire bits read as zero
          default: s_axi_rdata <= {16'h0000, channel_pair_a_mode};
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Interrupt and DMA requests
  // Recapture flags raise no request of their own
  assign timer_irq = |(event_status_flags[7:0] & dma_and_irq_enable[7:0]);
  assign dma_req = {dma_and_irq_enable[`TEF_BIT_DMA_TRG] & event_status_flags[`TEF_BIT_TRG],
                    dma_and_irq_enable[`TEF_BIT_DMA_HALL] & event_status_flags[`TEF_BIT_HALL],
                    dma_and_irq_enable[12:9] & event_status_flags[4:1],
                    dma_and_irq_enable[`TEF_BIT_DMA_OVF] & event_status_flags[`TEF_BIT_OVF]};

  // Channel 2 input source decode
  // Trigger capture is only valid with an internal trigger source
  wire [1:0] ch2_dir = channel_pair_a_mode[`TEF_BIT_CH2_DIR+1:`TEF_BIT_CH2_DIR];
  reg        ch2_src;
  reg        ch2_ok;
  always @* begin
    case (ch2_dir)
      `TEF_DIR_OUTPUT:  begin ch2_src = 1'b0; ch2_ok = 1'b0; end
      `TEF_DIR_OWN:     begin ch2_src = ch2_filtered_own; ch2_ok = 1'b1; end
      `TEF_DIR_CROSS:   begin ch2_src = ch1_filtered_to_ch2; ch2_ok = 1'b1; end
      `TEF_DIR_TRIGGER: begin
        ch2_src = internal_trigger_capture_src;
        ch2_ok  = trigger_source_internal;
      end
      default:          begin ch2_src = 1'b0; ch2_ok = 1'b0; end
    endcase
  end
  assign ch2_capture_input = ch2_src;
  assign ch2_capture_valid = ch2_ok;
  assign channel_pair_a_mode_q = channel_pair_a_mode;

  // Channel 1 raw reference, used only in output direction
  // Compares use the live counter; compare buffering lives upstream
  wire [1:0] ch1_dir = channel_pair_a_mode[`TEF_BIT_CH1_DIR+1:`TEF_BIT_CH1_DIR];
  wire [2:0] ch1_oc  = channel_pair_a_mode[6:4];
  wire       ch1_sw  = channel_pair_a_mode[`TEF_BIT_CH1_SW];
  wire       ch1_eq  = (counter_value == ch1_compare_value);
  wire       ch1_gt  = (ch1_compare_value > counter_value);
  wire       ch1_lt  = (ch1_compare_value < counter_value);
  assign ch1_output_connected = (ch1_dir == `TEF_DIR_OUTPUT) && (ch1_oc != `TEF_OC_OFF);
  reg next_raw;
  always @* begin
    next_raw = ch1_raw_output_ref;
    case (ch1_oc)
      `TEF_OC_OFF:    next_raw = ch1_raw_output_ref;
      `TEF_OC_SET:    if (ch1_eq) next_raw = 1'b1;
      `TEF_OC_CLEAR:  if (ch1_eq) next_raw = 1'b0;
      `TEF_OC_TOGGLE: if (ch1_eq) next_raw = !ch1_raw_output_ref;
      `TEF_OC_LOW:    next_raw = 1'b0;
      `TEF_OC_HIGH:   next_raw = 1'b1;
      `TEF_OC_PWM_A:  next_raw = count_down ? !ch1_lt : ch1_gt;
      `TEF_OC_PWM_B:  next_raw = count_down ? ch1_lt : !ch1_gt;
      default:        next_raw = 1'b0;
    endcase
    if (ch1_dir != `TEF_DIR_OUTPUT)
      next_raw = 1'b0;
    if (ch1_sw && clr_level)
      next_raw = 1'b0;
  end

  always @(posedge aclk) begin
    if (!aresetn)
      ch1_raw_output_ref <= 1'b0;
    else
      ch1_raw_output_ref <= next_raw;
  end

endmodule // tef_event_flags

// ==== sim/tef_event_flags_props.sv ====
// Purpose: Port-level checks on the timer event slice
// Assumes: One clock, synchronous active-low reset
// Notes:   Flag contents are judged by the bench
`timescale 1ns/10ps
module tef_event_flags_props (
  input wire        aclk,
  input wire        aresetn,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire [31:0] s_axi_rdata,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire [1:0]  s_axi_bresp,
  input wire [3:0]  has_complementary,
  input wire [3:0]  commutation_apply,
  input wire        clear_input_pin,
  input wire        trigger_source_internal,
  input wire        ch1_filtered_to_ch2,
  input wire        ch2_filtered_own,
  input wire        internal_trigger_capture_src,
  input wire        ch2_capture_input,
  input wire        ch2_capture_valid,
  input wire        ch1_raw_output_ref,
  input wire        ch1_output_connected,
  input wire [15:0] channel_pair_a_mode_q
);
  wire [1:0] c2 = channel_pair_a_mode_q[9:8];
  wire [7:0] m = channel_pair_a_mode_q[7:0];
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
    && s_axi_bresp == 2'h0) else $error("write response dropped early");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata)) else $error("read data not held");
  read_latency_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid
    && s_axi_rdata[31:16] == 16'h0000) else $error("read answer late or wide");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("address taken while answer pending");
  commut_mask_a: assert property ((commutation_apply & ~has_complementary) == 4'h0)
    else $error("commutation on plain channel");
  ch2_valid_a: assert property (ch2_capture_valid == (c2 != 2'h0 &&
    (c2 != 2'h3 || trigger_source_internal))) else $error("ch2 capture valid wrong");
  ch2_source_a: assert property (c2 != 2'h0 |-> ch2_capture_input == (c2 == 2'h1 ?
    ch2_filtered_own : c2 == 2'h2 ? ch1_filtered_to_ch2 : internal_trigger_capture_src))
    else $error("ch2 capture source wrong");
  clear_force_a: assert property ((m[7] && clear_input_pin)[*6] |=> !ch1_raw_output_ref)
    else $error("clear input did not force low");
  connect_a: assert property (m[1:0] == 2'h0 |-> ch1_output_connected == (m[6:4] != 3'h0))
    else $error("output connection wrong");
  force_high_a: assert property ((m[6:4] == 3'h5 && m[7] == 1'b0 && m[1:0] == 2'h0)[*2]
    |=> ch1_raw_output_ref) else $error("force high not seen");
  cover property (s_axi_bvalid && s_axi_bready);
  cover property (|commutation_apply);
  cover property (c2 == 2'h3 && ch2_capture_valid);
endmodule // tef_event_flags_props
bind tef_event_flags tef_event_flags_props tef_event_flags_props_inst (.*);

// ==== sim/tb_tef_event_flags.sv ====
// Purpose: Register-level test of the timer event slice
// Assumes: AXI4-Lite master, 50 ns clock
// Notes:   Synced inputs need several edges before flags move
`timescale 1ns/10ps
module tb_tef_event_flags;
  reg         aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  reg         s_axi_rready, break_active, slave_trigger_line, clear_input_pin, count_down;
  reg         trigger_source_internal, overflow_event_disable, overflow_source_select;
  reg  [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb, channel_enable_bit;
  reg  [3:0]  has_complementary, ch_is_input;
  reg  [3:0]  capp = 4'h0;
  reg  [31:0] s_axi_wdata;
  reg  [2:0]  slave_mode;
  reg  [15:0] p, cval;
  wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0]  s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire        timer_irq, sw_trigger_pulse, sw_break_pulse, ch2_capture_input;
  wire        ch2_capture_valid, ch1_raw_output_ref, ch1_output_connected;
  wire [6:0]  dma_req;
  wire [3:0]  commutation_apply;
  wire [15:0] channel_pair_a_mode_q;
  wire        ch1_filtered_own = 1'b1, ch1_filtered_to_ch2 = 1'b0;
  wire        ch2_filtered_own = 1'b1, internal_trigger_capture_src = 1'b0;
  integer     failures, checked, n, k;
  integer     ntrg = 0, nbrk = 0;
  tef_event_flags tef_event_flags_inst (.*, .counter_overflow(p[0]), .trigger_reinit(p[1]),
    .preload_update(p[2]), .capture_event(p[7:4]), .compare_event(p[11:8]),
    .data_reg_read(p[15:12]), .counter_value(cval), .ch1_compare_value(16'h0008));
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    ntrg = ntrg + sw_trigger_pulse;
    nbrk = nbrk + sw_break_pulse;
    capp = capp | commutation_apply;
  end
  task stop_test;
    begin
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
    end
  endtask
  task chk(input [31:0] g, input [31:0] e);
    begin
      checked = checked + 1;
      if (g !== e) begin
        failures = failures + 1;
        $display("unexpected at %0t: got %h want %h", $time, g, e);
      end
    end
  endtask
  // A hung handshake is a fault, not a wait
  task tmo;
    if (n >= 50) begin
      failures = failures + 1;
      stop_test;
    end
  endtask
  task wr(input [3:0] a, input [31:0] d);
    begin
      s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1; n = 0;
      do begin
        @(posedge aclk);
        if (s_axi_awready) s_axi_awvalid <= 1'b0;
        if (s_axi_wready) s_axi_wvalid <= 1'b0;
        n = n + 1;
      end while (!s_axi_bvalid && n < 50);
      tmo;
    end
  endtask
  task rd(input [3:0] a, input [31:0] e);
    begin
      s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1; n = 0;
      do begin
        @(posedge aclk);
        if (s_axi_arready) s_axi_arvalid <= 1'b0;
        n = n + 1;
      end while (!s_axi_rvalid && n < 50);
      tmo;
      chk(s_axi_rdata, e);
    end
  endtask
  task pl(input [15:0] v);
    begin
      p <= v; @(posedge aclk); p <= 16'h0000; @(posedge aclk);
    end
  endtask
  task tk(input integer c);
    repeat (c) @(posedge aclk);
  endtask
  initial begin
    repeat (20000) @(posedge aclk);
    failures = failures + 1;
    stop_test;
  end
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 0;
    {break_active, slave_trigger_line, clear_input_pin, trigger_source_internal} = 0;
    {overflow_event_disable, overflow_source_select, slave_mode, p, cval, count_down} = 0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, channel_enable_bit, ch_is_input} = 0;
    s_axi_wstrb = 4'hf; has_complementary = 4'h5;
    {failures, checked} = 0;
    tk(8); aresetn <= 1'b1; tk(1);
    rd(4'h0, 0); rd(4'h4, 0); rd(4'hc, 0);
    wr(4'h0, 32'hffffffff); rd(4'h0, 32'h7fff);
    pl(16'h0101); pl(16'h1000); rd(4'h4, 32'h3);
    chk({timer_irq, dma_req}, 8'h83);
    wr(4'h4, 32'h1efd); rd(4'h4, 32'h1);
    ch_is_input <= 4'h1; pl(16'h0010); pl(16'h0010); rd(4'h4, 32'h203);
    pl(16'h1000); rd(4'h4, 32'h201);
    wr(4'h0, 0); wr(4'h4, 0); pl(16'h0001); chk({timer_irq, dma_req}, 0);
    wr(4'h4, 0); pl(16'h0002); rd(4'h4, 32'h1);
    wr(4'h4, 0); wr(4'h8, 32'h1); rd(4'h4, 32'h1);
    overflow_event_disable <= 1'b1; wr(4'h4, 0); pl(16'h0002); wr(4'h8, 32'h1);
    rd(4'h4, 0); pl(16'h0001); rd(4'h4, 32'h1); overflow_event_disable <= 1'b0;
    wr(4'h4, 0); wr(4'h8, 32'h7e); tk(2); rd(4'h4, 32'h7e);
    chk(capp, 4'h5); chk(ntrg, 1); wr(4'h8, 0); wr(4'h8, 32'h80); tk(2);
    chk(nbrk, 1); chk(ntrg, 1); rd(4'h8, 0);
    break_active <= 1'b1; tk(6); wr(4'h4, 0); rd(4'h4, 32'h80);
    break_active <= 1'b0; tk(6); wr(4'h4, 0); rd(4'h4, 0);
    slave_trigger_line <= 1'b1; tk(6); rd(4'h4, 32'h40); wr(4'h4, 0);
    slave_trigger_line <= 1'b0; tk(6); rd(4'h4, 0); slave_mode <= 3'h5;
    slave_trigger_line <= 1'b1; tk(6); wr(4'h4, 0);
    slave_trigger_line <= 1'b0; tk(6); rd(4'h4, 32'h40);
    wr(4'h4, 0); pl(16'h0004); rd(4'h4, 32'h20);
    wr(4'hc, 32'hffff); rd(4'hc, 32'hffff); chk(channel_pair_a_mode_q, 16'hffff);
    for (k = 0; k < 8; k = k + 1) begin
      wr(4'hc, k << 4); chk(ch1_output_connected, k != 0);
    end
    wr(4'hc, 32'h50); tk(2); chk(ch1_raw_output_ref, 1);
    wr(4'hc, 32'h40); tk(2); chk(ch1_raw_output_ref, 0);
    wr(4'hc, 32'hd0); clear_input_pin <= 1'b1; tk(8); chk(ch1_raw_output_ref, 0);
    wr(4'hc, 32'h50); tk(8); chk(ch1_raw_output_ref, 1);
    clear_input_pin <= 1'b0; cval <= 16'h0004; wr(4'hc, 32'h40); wr(4'hc, 32'h10);
    tk(2); chk(ch1_raw_output_ref, 0); cval <= 16'h0008;
    tk(2); chk(ch1_raw_output_ref, 1);
    wr(4'hc, 32'h20); tk(2); chk(ch1_raw_output_ref, 0);
    cval <= 16'h0004; wr(4'hc, 32'h60); tk(2); chk(ch1_raw_output_ref, 1);
    cval <= 16'h000c; tk(2); chk(ch1_raw_output_ref, 0);
    count_down <= 1'b1; wr(4'hc, 32'h70); tk(2); chk(ch1_raw_output_ref, 1);
    for (k = 0; k < 8; k = k + 1) begin
      trigger_source_internal <= k[2]; wr(4'hc, {k[1:0], 8'h00});
      chk(ch2_capture_valid, k[1:0] != 0 && (k[1:0] != 3 || k[2]));
    end
    stop_test;
  end
endmodule // tb_tef_event_flags
